// File: core/wdrt_pkg.sv
package wdrt_pkg;

	// register addresses on the peripheral bus
	localparam logic [15:0] WDRT_ADDR_TICK = 16'h7021;
	localparam logic [15:0] WDRT_ADDR_WDCNT = 16'h7023;
	localparam logic [15:0] WDRT_ADDR_KEY = 16'h7025;
	localparam logic [15:0] WDRT_ADDR_PCTL = 16'h7027;
	localparam logic [15:0] WDRT_ADDR_WCTL = 16'h7029;

	// service key values
	localparam logic [7:0] WDRT_KEY_ARM = 8'h55;
	localparam logic [7:0] WDRT_KEY_CLR = 8'hAA;

	// periodic control fields
	localparam int WDRT_PCTL_FLAG = 7;
	localparam int WDRT_PCTL_ENA = 6;
	localparam int WDRT_PCTL_PS_HI = 2;

	// watchdog control fields
	localparam int WDRT_WCTL_FLAG = 7;
	localparam int WDRT_WCTL_DIS = 6;
	localparam int WDRT_WCTL_CHK_HI = 5;
	localparam int WDRT_WCTL_CHK_LO = 3;
	localparam int WDRT_WCTL_PS_HI = 2;

	// reset and constant values
	localparam logic [2:0] WDRT_CHK_OK = 3'h5;
	localparam logic [2:0] WDRT_PS_RST = 3'h0;
	localparam logic [7:0] WDRT_CNT_RST = 8'h00;
	localparam logic [7:0] WDRT_CNT_MAX = 8'hFF;
	localparam logic [6:0] WDRT_FR_RST = 7'h00;
	localparam logic [2:0] WDRT_TAP_TICK = 3'h7;

	// true when the low n bits of v are all ones, i.e. bit n-1 carries on the next step
	function automatic logic wdrt_tap_hit(input logic [7:0] v, input logic [2:0] n);
		logic [7:0] m;
		m = (8'h01 << n) - 8'h01;
		return (v & m) == m;
	endfunction : wdrt_tap_hit

	// periodic select: codes 0-3 use free-running taps, codes 4-7 use tick counter taps
	function automatic logic [2:0] wdrt_per_tap(input logic [2:0] code);
		case (code)
			3'h0: return 3'h2;
			3'h1: return 3'h4;
			3'h2: return 3'h5;
			3'h3: return 3'h7;
			3'h4: return 3'h1;
			3'h5: return 3'h3;
			3'h6: return 3'h5;
			default: return 3'h7;
		endcase
	endfunction : wdrt_per_tap

	typedef enum logic [1:0] {
		wdrt_key_idle = 2'b01,
		wdrt_key_armed = 2'b10
	} wdrt_key_st_t;

endpackage : wdrt_pkg

// File: core/wdrt_evt_if.sv
`timescale 1ns/1ps
interface wdrt_evt_if;
	logic base_tick;
	logic [6:0] fr_q;
	logic key_wr;
	logic [7:0] key_data;
	logic key_clr;
	logic key_bad;

	modport tick_src (output base_tick, output fr_q);
	modport key_side (input key_wr, input key_data, output key_clr, output key_bad);
	modport core (input base_tick, input fr_q, output key_wr, output key_data,
		input key_clr, input key_bad);
endinterface : wdrt_evt_if

// File: core/wdrt_tick_gen.sv
`timescale 1ns/1ps
module wdrt_tick_gen (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic sys_reset,
	input wire logic watchdog_base_clock,
	wdrt_evt_if.tick_src evt
);
	import wdrt_pkg::*;

	logic base_q;
	logic [6:0] fr_q;
	logic [6:0] fr_d;

	// one pulse per rising edge of the slow base clock
	assign evt.base_tick = watchdog_base_clock & ~base_q;
	assign evt.fr_q = fr_q;
	assign fr_d = sys_reset ? WDRT_FR_RST : (evt.base_tick ? fr_q + 7'h01 : fr_q);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			base_q <= 1'b0;
			fr_q <= WDRT_FR_RST;
		end else begin
			base_q <= watchdog_base_clock;
			fr_q <= fr_d;
		end
	end

	prescaler_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
		evt.base_tick && !sys_reset |=> fr_q == $past(fr_q) + 7'h01)
		else $error("prescaler did not advance on base tick");

endmodule : wdrt_tick_gen

// File: core/wdrt_key_guard.sv
`timescale 1ns/1ps
module wdrt_key_guard (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic sys_reset,
	wdrt_evt_if.key_side evt
);
	import wdrt_pkg::*;

	wdrt_key_st_t st_q;
	wdrt_key_st_t st_d;
	logic is_arm;
	logic is_clr;

	assign is_arm = evt.key_wr && evt.key_data == WDRT_KEY_ARM;
	assign is_clr = evt.key_wr && evt.key_data == WDRT_KEY_CLR;
	assign evt.key_clr = is_clr && st_q == wdrt_key_armed;
	assign evt.key_bad = evt.key_wr && !is_arm && !is_clr;

	always_comb begin
		st_d = st_q;
		case (st_q)
			wdrt_key_idle: begin
				if (is_arm) begin
					st_d = wdrt_key_armed;
				end
			end
			wdrt_key_armed: begin
				if (is_clr) begin
					st_d = wdrt_key_idle;
				end
			end
			default: st_d = wdrt_key_idle;
		endcase
		if (sys_reset) begin
			st_d = wdrt_key_idle;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= wdrt_key_idle;
		end else begin
			st_q <= st_d;
		end
	end

	good_key_safe_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(is_arm || is_clr) |-> !evt.key_bad)
		else $error("valid key value flagged as bad");

endmodule : wdrt_key_guard

// File: core/wdrt_top.sv
// Notes on behaviour
// - 8-bit watchdog count, readable, steps per tick
// - reset one count-clock period after overflow
// - 55h arms, next AAh clears count, disarms
// - any other key value resets immediately
// - repeated 55h/AAh mixes never reset
// - overflow or bad key sets surviving flag
// - 7-bit prescaler free-runs, only system reset clears
// - 3-bit select picks base clock or tap
// - reset gives fastest rate, counting starts immediately
// - watchdog runs whenever base clock runs, unless strap plus bit 6 disable it
// - disable needs strap at reset plus bit 6
// - check bits not 101 force reset
// - tick counter advances on divide-by-128 tap
// - 1-of-8 mux selects periodic interrupt source
// - periodic rates span 1 to 4096 per second
// - tick counter clearable without touching prescaler
// - periodic timer stops in halt, enable gates
// - tick counter readable; prescaler reset-only
// - periodic flag sets on overflow, write-0 clears
// - one request per edge; disable drops pending
// - key location reads back watchdog control
// - any write to tick counter clears it
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module wdrt_top (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic sys_reset,
	input wire logic watchdog_base_clock,
	input wire logic programming_supply_pin,
	input wire logic halt_mode,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [7:0] rdata,
	output logic periodic_interrupt,
	input wire logic periodic_interrupt_ack,
	output logic wd_reset_req
);
	import wdrt_pkg::*;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	wdrt_evt_if evt ();

	// register state
	logic [7:0] tick_q;
	logic [7:0] tick_d;
	logic [7:0] wd_count_q;
	logic [7:0] wd_count_d;
	logic ovf_pend_q;
	logic ovf_pend_d;
	logic wd_flag_q;
	logic wd_flag_d;
	logic wd_dis_q;
	logic [2:0] chk_q;
	logic [2:0] wd_ps_q;
	logic p_flag_q;
	logic p_flag_d;
	logic p_ena_q;
	logic [2:0] p_ps_q;
	logic irq_q;
	logic irq_d;
	logic strap_q;
	logic wd_reset_q;
	logic wd_reset_d;
	logic [7:0] rdata_q;

	// decode
	logic wr_tick;
	logic wr_key;
	logic wr_pctl;
	logic wr_wctl;
	logic [7:0] wctl_rd;
	logic [7:0] pctl_rd;
	logic [7:0] rdata_d;

	// time base
	logic [7:0] fr_ext;
	logic tap128;
	logic wd_tick;
	logic wd_run;
	logic wd_ovf;
	logic chk_bad;
	logic rst_cause;
	logic wd_cause;
	logic per_src;
	logic per_evt;
	logic [2:0] per_n;

	wdrt_tick_gen u_tick (
		.mclk(mclk),
		.rst_n(rst_n),
		.sys_reset(sys_reset),
		.watchdog_base_clock(watchdog_base_clock),
		.evt(evt.tick_src)
	);

	wdrt_key_guard u_key (
		.mclk(mclk),
		.rst_n(rst_n),
		.sys_reset(sys_reset),
		.evt(evt.key_side)
	);

	assign wr_tick = wr_stb && addr == WDRT_ADDR_TICK;
	assign wr_key = wr_stb && addr == WDRT_ADDR_KEY;
	assign wr_pctl = wr_stb && addr == WDRT_ADDR_PCTL;
	assign wr_wctl = wr_stb && addr == WDRT_ADDR_WCTL;

	assign evt.key_wr = wr_key && !sys_reset;
	assign evt.key_data = wdata;

	// ---- watchdog counter clock
	assign fr_ext = {1'b0, evt.fr_q};
	// codes 0 and 1 take the base clock directly, 2..7 take divide by 2..64
	assign wd_tick = evt.base_tick &&
		(wd_ps_q < 3'h2 || wdrt_tap_hit(fr_ext, wd_ps_q - 3'h1));
	// the strap and the disable bit must both hold, else the count never stops
	assign wd_run = !(strap_q && wd_dis_q);
	assign wd_ovf = wd_run && wd_tick && wd_count_q == WDRT_CNT_MAX;
	assign chk_bad = chk_q != WDRT_CHK_OK;

	// watchdog causes; an armed overflow fires on the next count-clock tick
	assign wd_cause = !sys_reset &&
		((wd_run && ovf_pend_q && wd_tick && !evt.key_clr) || evt.key_bad);
	// corrupted check bits reset as well, but do not mark the flag
	assign rst_cause = wd_cause || (!sys_reset && chk_bad);

	always_comb begin
		wd_count_d = wd_count_q;
		ovf_pend_d = ovf_pend_q;
		if (wd_run && wd_tick) begin
			wd_count_d = wd_count_q + 8'h01;
		end
		if (wd_ovf) begin
			ovf_pend_d = 1'b1;
		end
		if (evt.key_clr) begin
			wd_count_d = WDRT_CNT_RST;
			ovf_pend_d = 1'b0;
		end
		if (sys_reset) begin
			wd_count_d = WDRT_CNT_RST;
			ovf_pend_d = 1'b0;
		end
	end

	// flag survives system reset; a new cause wins over a software clear
	always_comb begin
		wd_flag_d = wd_flag_q;
		if (wr_wctl && !wdata[WDRT_WCTL_FLAG]) begin
			wd_flag_d = 1'b0;
		end
		if (wd_cause) begin
			wd_flag_d = 1'b1;
		end
	end

	// reset request held until the system reset comes back
	assign wd_reset_d = sys_reset ? 1'b0 : (wd_reset_q || rst_cause);

	// ---- periodic tick
	assign tap128 = evt.base_tick && wdrt_tap_hit(fr_ext, WDRT_TAP_TICK) && !halt_mode;
	assign per_n = wdrt_per_tap(p_ps_q);
	// codes 0-3 from the prescaler, 4-7 from the tick counter on its /128 clock
	assign per_src = p_ps_q[WDRT_PCTL_PS_HI] ? (tap128 && wdrt_tap_hit(tick_q, per_n)) :
		(evt.base_tick && wdrt_tap_hit(fr_ext, per_n));
	assign per_evt = per_src && !halt_mode && !sys_reset;

	always_comb begin
		tick_d = tick_q;
		if (tap128) begin
			tick_d = tick_q + 8'h01;
		end
		if (wr_tick || sys_reset) begin
			tick_d = WDRT_CNT_RST;
		end
	end

	always_comb begin
		p_flag_d = p_flag_q;
		if (wr_pctl) begin
			p_flag_d = wdata[WDRT_PCTL_FLAG];
		end
		if (per_evt) begin
			p_flag_d = 1'b1;
		end
		if (sys_reset) begin
			p_flag_d = 1'b0;
		end
	end

	// a software-set flag never reaches the request path
	always_comb begin
		irq_d = irq_q;
		if (periodic_interrupt_ack) begin
			irq_d = 1'b0;
		end
		if (per_evt && p_ena_q) begin
			irq_d = 1'b1;
		end
		if ((wr_pctl && !wdata[WDRT_PCTL_ENA]) || sys_reset) begin
			irq_d = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wd_count_q <= WDRT_CNT_RST;
			ovf_pend_q <= 1'b0;
			wd_flag_q <= 1'b0;
			wd_reset_q <= 1'b0;
			tick_q <= WDRT_CNT_RST;
			p_flag_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			wd_count_q <= wd_count_d;
			ovf_pend_q <= ovf_pend_d;
			wd_flag_q <= wd_flag_d;
			wd_reset_q <= wd_reset_d;
			tick_q <= tick_d;
			p_flag_q <= p_flag_d;
			irq_q <= irq_d;
		end
	end

	// control fields; check bits return to the good pattern at reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wd_dis_q <= 1'b0;
			chk_q <= WDRT_CHK_OK;
			wd_ps_q <= WDRT_PS_RST;
			p_ena_q <= 1'b0;
			p_ps_q <= WDRT_PS_RST;
		end else if (sys_reset) begin
			wd_dis_q <= 1'b0;
			chk_q <= WDRT_CHK_OK;
			wd_ps_q <= WDRT_PS_RST;
			p_ena_q <= 1'b0;
			p_ps_q <= WDRT_PS_RST;
		end else begin
			if (wr_wctl) begin
				wd_dis_q <= wdata[WDRT_WCTL_DIS];
				chk_q <= wdata[WDRT_WCTL_CHK_HI:WDRT_WCTL_CHK_LO];
				wd_ps_q <= wdata[WDRT_WCTL_PS_HI:0];
			end
			if (wr_pctl) begin
				p_ena_q <= wdata[WDRT_PCTL_ENA];
				p_ps_q <= wdata[WDRT_PCTL_PS_HI:0];
			end
		end
	end

	// strap sampled while system reset is held
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			strap_q <= 1'b0;
		end else if (sys_reset) begin
			strap_q <= programming_supply_pin;
		end
	end

	// ---- read path
	assign wctl_rd = {wd_flag_q, wd_dis_q, chk_q, wd_ps_q};
	assign pctl_rd = {p_flag_q, p_ena_q, 3'h0, p_ps_q};
	assign rdata_d = !rd_stb ? 8'h00 :
		addr == WDRT_ADDR_TICK ? tick_q :
		addr == WDRT_ADDR_WDCNT ? wd_count_q :
		addr == WDRT_ADDR_KEY ? wctl_rd :
		addr == WDRT_ADDR_PCTL ? pctl_rd :
		addr == WDRT_ADDR_WCTL ? wctl_rd : 8'h00;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign rdata = rdata_q;
	assign periodic_interrupt = irq_q;
	assign wd_reset_req = wd_reset_q;

	// ---- checks
	sequence wrap_s;
		wd_ovf && !sys_reset && !evt.key_clr;
	endsequence

	sequence next_tick_s;
		wd_tick && !sys_reset && !evt.key_clr && !evt.key_bad;
	endsequence

	wd_count_step_a: assert property (
		wd_run && wd_tick && !evt.key_clr && !sys_reset |=> wd_count_q == $past(wd_count_q) + 8'h01)
		else $error("watchdog count did not step");

	ovf_no_early_a: assert property (
		(wrap_s and (!evt.key_bad && !chk_bad && !wd_reset_q)) ##1
		(!wd_tick && !evt.key_bad && !chk_bad) |=> !wd_reset_q)
		else $error("reset raised before one count period after overflow");

	ovf_then_reset_a: assert property (
		(next_tick_s and (ovf_pend_q && wd_run)) |=> wd_reset_q)
		else $error("no reset one count period after overflow");

	key_clear_a: assert property (
		evt.key_clr && !sys_reset |=> wd_count_q == WDRT_CNT_RST && !ovf_pend_q)
		else $error("service key did not clear the count");

	bad_key_a: assert property (
		wr_key && wdata != WDRT_KEY_ARM && wdata != WDRT_KEY_CLR && !sys_reset
		|=> wd_reset_q && wd_flag_q)
		else $error("bad key did not reset");

	flag_keep_a: assert property (
		wd_flag_q && sys_reset && !wr_wctl |=> wd_flag_q)
		else $error("watchdog flag lost across system reset");

	check_bits_a: assert property (
		chk_q != WDRT_CHK_OK && !sys_reset |=> wd_reset_q)
		else $error("bad check bits did not reset");

	tick_clear_a: assert property (
		wr_tick && !sys_reset |=> tick_q == WDRT_CNT_RST)
		else $error("tick counter write did not clear");

	irq_drop_a: assert property (
		wr_pctl && !wdata[WDRT_PCTL_ENA] |=> !periodic_interrupt ##1 !periodic_interrupt)
		else $error("pending request survived disable");

	key_read_a: assert property (
		rd_stb && addr == WDRT_ADDR_KEY && !wr_wctl && !rst_cause && !sys_reset
		|=> rdata == $past(wctl_rd))
		else $error("key location did not read watchdog control");

endmodule : wdrt_top

// File: verification/wdrt_top_tb.sv
`timescale 1ns/1ps
module wdrt_top_tb;
	import wdrt_pkg::*;

	logic mclk, rst_n, sys_reset, watchdog_base_clock, programming_supply_pin, halt_mode;
	logic [15:0] addr;
	logic [7:0] wdata, rdata, v;
	logic wr_stb, rd_stb, periodic_interrupt, periodic_interrupt_ack, wd_reset_req;
	int errors, compares, seed, taps[8];
	// reference state of the block
	logic [6:0] fr;
	logic [7:0] wd, rt, keys[9];
	logic [2:0] wps, pcode;
	logic ovp, rq_m, armed, pf, en, irq, dis_m;

	wdrt_top i_wdrt_top (.mclk(mclk), .rst_n(rst_n), .sys_reset(sys_reset),
		.watchdog_base_clock(watchdog_base_clock),
		.programming_supply_pin(programming_supply_pin), .halt_mode(halt_mode),
		.addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
		.periodic_interrupt(periodic_interrupt),
		.periodic_interrupt_ack(periodic_interrupt_ack), .wd_reset_req(wd_reset_req));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic give_verdict;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict

	initial begin
		repeat (100000) @(posedge mclk);
		errors++;
		give_verdict();
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
	endtask : wr

	task automatic rdchk(input logic [15:0] a, input logic [7:0] exp, input string what);
		@(posedge mclk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		#1;
		chk(rdata, exp, what);
	endtask : rdchk

	function automatic logic [7:0] ones(input int n);
		return (8'h01 << n) - 8'h01;
	endfunction : ones

	function automatic logic per_ev(input logic [2:0] c, input logic [6:0] f,
		input logic [7:0] r);
		if (c < 3'h4) begin
			return ({1'b0, f} & ones(taps[c])) == ones(taps[c]);
		end
		return f == 7'h7F && (r & ones(taps[c])) == ones(taps[c]);
	endfunction : per_ev

	// one base tick is a rising edge held for one mclk cycle
	task automatic tick(input int n);
		logic cnt_t, ev;
		@(posedge mclk);
		repeat (n) begin
			watchdog_base_clock <= 1'b1;
			@(posedge mclk);
			watchdog_base_clock <= 1'b0;
			@(posedge mclk);
			cnt_t = !dis_m && (wps < 3'h2 || ({1'b0, fr} & ones(int'(wps) - 1)) == ones(int'(wps) - 1));
			if (cnt_t) begin
				if (ovp) rq_m = 1'b1;
				if (wd == 8'hFF) ovp = 1'b1;
				wd = wd + 8'h01;
			end
			ev = !halt_mode && per_ev(pcode, fr, rt);
			if (!halt_mode && fr == 7'h7F) rt = rt + 8'h01;
			if (ev) begin
				pf = 1'b1;
				if (en) irq = 1'b1;
			end
			fr = fr + 7'h01;
		end
		repeat (6) @(posedge mclk);
	endtask : tick

	task automatic sysrst;
		@(posedge mclk);
		sys_reset <= 1'b1;
		repeat (3) @(posedge mclk);
		sys_reset <= 1'b0;
		repeat (2) @(posedge mclk);
		{fr, wd, rt, wps, pcode} = '0;
		{ovp, rq_m, armed, pf, en, irq, dis_m} = '0;
		#1;
		chk({7'h00, wd_reset_req}, 8'h00, "reset request after system reset");
	endtask : sysrst

	task automatic kclr;
		wr(WDRT_ADDR_KEY, WDRT_KEY_ARM);
		wr(WDRT_ADDR_KEY, WDRT_KEY_CLR);
		wd = 8'h00;
		ovp = 1'b0;
		armed = 1'b0;
	endtask : kclr

	task automatic req_is(input logic exp, input string what);
		repeat (2) @(posedge mclk);
		#1;
		chk({7'h00, wd_reset_req}, {7'h00, exp}, what);
	endtask : req_is

	initial begin
		seed = 44;
		taps = '{2, 4, 5, 7, 1, 3, 5, 7};
		keys = '{8'hAA, 8'hAA, 8'h55, 8'h55, 8'h55, 8'hAA, 8'hAA, 8'h55, 8'hAA};
		{fr, wd, rt, wps, pcode} = '0;
		{ovp, rq_m, armed, pf, en, irq, dis_m} = '0;
		{rst_n, sys_reset, watchdog_base_clock, programming_supply_pin, halt_mode} = '0;
		{addr, wdata, wr_stb, rd_stb, periodic_interrupt_ack} = '0;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		rdchk(WDRT_ADDR_WCTL, 8'h28, "watchdog control default");
		rdchk(WDRT_ADDR_KEY, 8'h28, "key location readback");
		rdchk(WDRT_ADDR_PCTL, 8'h00, "periodic control default");
		rdchk(16'h7020, 8'h00, "unmapped read");
		tick(37);
		wr(WDRT_ADDR_WDCNT, 8'h5A);
		rdchk(WDRT_ADDR_WDCNT, wd, "count after power-up");
		// service key sequence with counting in between
		foreach (keys[i]) begin
			tick(3);
			wr(WDRT_ADDR_KEY, keys[i]);
			if (keys[i] == WDRT_KEY_ARM) armed = 1'b1;
			else if (armed) {wd, ovp, armed} = '0;
			rdchk(WDRT_ADDR_WDCNT, wd, "count in key sequence");
			req_is(1'b0, "no reset from legal keys");
		end
		for (int c = 0; c < 8; c++) begin
			wr(WDRT_ADDR_WCTL, 8'h28 | 8'(c));
			wps = 3'(c);
			kclr();
			tick(1 + $unsigned($random(seed)) % 120);
			rdchk(WDRT_ADDR_WDCNT, wd, "count per prescale code");
		end
		wr(WDRT_ADDR_WCTL, 8'h28);
		wps = 3'h0;
		kclr();
		tick(256);
		req_is(1'b0, "no reset on the wrap itself");
		rdchk(WDRT_ADDR_WDCNT, 8'h00, "count wrapped");
		tick(1);
		req_is(1'b1, "reset one count clock after overflow");
		sysrst();
		rdchk(WDRT_ADDR_WCTL, 8'hA8, "flag after overflow reset");
		wr(WDRT_ADDR_WCTL, 8'h28);
		rdchk(WDRT_ADDR_WCTL, 8'h28, "flag cleared");
		v = 8'($random(seed));
		if (v == WDRT_KEY_ARM || v == WDRT_KEY_CLR) v = 8'h23;
		wr(WDRT_ADDR_KEY, v);
		req_is(1'b1, "bad key reset");
		sysrst();
		rdchk(WDRT_ADDR_WCTL, 8'hA8, "flag after bad key");
		wr(WDRT_ADDR_WCTL, 8'h28);
		wr(WDRT_ADDR_WCTL, {2'b00, 3'(3'h5 ^ (3'h1 + 3'($unsigned($random(seed)) % 7))), 3'h0});
		req_is(1'b1, "check bits reset");
		sysrst();
		rdchk(WDRT_ADDR_WCTL, 8'h28, "check bits leave flag clear");
		for (int p = 1; p >= 0; p--) begin
			@(posedge mclk);
			programming_supply_pin <= p[0];
			sysrst();
			programming_supply_pin <= 1'b0;
			wr(WDRT_ADDR_WCTL, 8'h68);
			dis_m = p[0];
			tick(20);
			rdchk(WDRT_ADDR_WDCNT, wd, "count with disable bit");
		end
		sysrst();
		wr(WDRT_ADDR_WCTL, 8'h2F);
		wps = 3'h7;
		for (int c = 0; c < 8; c++) begin
			@(posedge mclk);
			halt_mode <= (c == 5);
			wr(WDRT_ADDR_TICK, 8'($random(seed)));
			rt = 8'h00;
			rdchk(WDRT_ADDR_TICK, 8'h00, "tick counter cleared by write");
			kclr();
			wr(WDRT_ADDR_PCTL, 8'h40 | 8'(c));
			{pf, en, irq, pcode} = {3'b010, 3'(c)};
			tick(100 + $unsigned($random(seed)) % 300);
			rdchk(WDRT_ADDR_TICK, rt, "tick counter");
			rdchk(WDRT_ADDR_PCTL, {pf, en, 3'b000, pcode}, "periodic control");
			chk({7'h00, periodic_interrupt}, {7'h00, irq}, "periodic request");
			if (c[0]) begin
				@(posedge mclk);
				periodic_interrupt_ack <= 1'b1;
				@(posedge mclk);
				periodic_interrupt_ack <= 1'b0;
			end else begin
				wr(WDRT_ADDR_PCTL, 8'h80 | 8'(c));
			end
			repeat (2) @(posedge mclk);
			#1;
			chk({7'h00, periodic_interrupt}, 8'h00, "request dropped");
		end
		halt_mode <= 1'b0;
		give_verdict();
	end
endmodule : wdrt_top_tb
